// ==== inc/stx_pkg.sv ====
package stx_pkg;
  // ----------------------------------------------------------------
  // Opcode patterns
  // ----------------------------------------------------------------
  localparam logic [6:0] OP_TEST_SKIP_HI = 7'h33;
  localparam logic [7:0] OP_XOR_LIT_HI = 8'h0a;
  localparam logic [5:0] OP_TABLE_WR_HI = 6'h03;
  localparam logic [13:0] OP_TABLE_WR_BASE = 14'h0003;
  localparam logic [3:0] OP_TWO_WORD_A = 4'hc;
  localparam logic [3:0] OP_TWO_WORD_B = 4'he;
  localparam logic [2:0] OP_TWO_WORD_B_SUB = 3'h5;
  localparam logic [7:0] OP_TWO_WORD_C = 8'hee;
  localparam logic [7:0] OP_TWO_WORD_D = 8'hef;
  localparam logic [7:0] OP_TWO_WORD_E = 8'hec;
  localparam logic [7:0] OP_TWO_WORD_F = 8'hed;
  localparam logic [7:0] INDEX_LIMIT = 8'h5f;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // Table write pointer modes (low two opcode bits).
  localparam logic [1:0] TW_PLAIN = 2'h0;
  localparam logic [1:0] TW_POSTINC = 2'h1;
  localparam logic [1:0] TW_POSTDEC = 2'h2;
  localparam logic [1:0] TW_PREINC = 2'h3;
  // ----------------------------------------------------------------
  // AXI4-Lite map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_INSTR = 8'h04;
  localparam logic [7:0] REG_WREG = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_FILE_ADDR = 8'h10;
  localparam logic [7:0] REG_FILE_DATA = 8'h14;
  localparam logic [7:0] REG_TPTR = 8'h18;
  localparam logic [7:0] REG_TLAT = 8'h1c;
  localparam logic [7:0] REG_HOLD_ADDR = 8'h20;
  localparam logic [7:0] REG_HOLD_DATA = 8'h24;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CTRL_XINST_BIT = 0;
  localparam int CTRL_BANK_LSB = 8;
  localparam int CTRL_BASE_LSB = 16;
  localparam int ST_N_BIT = 4;
  localparam int ST_Z_BIT = 2;
  localparam int ST_BUSY_BIT = 8;
  localparam int ST_SKIP_BIT = 9;
  localparam int ST_CYC_LSB = 12;
  localparam logic [4:0] STATUS_RST = 5'h00;
  typedef enum logic [2:0] {STX_IDLE, STX_EXEC, STX_SKIP1, STX_SKIP2, STX_TW2} stx_state_t;
endpackage

// ==== core/stx_mem.sv ====
`timescale 1ns/1ps
module stx_mem #(
  parameter int AW = 8
) (
  input wire logic aclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [2**AW];
  // Read data is registered, so a lookup costs one clock.
  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// ==== core/stx_core.sv ====
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module stx_core import stx_pkg::*; #(
  parameter int FAW = 12,
  parameter int HAW = 6
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // The address logic builds exactly twelve bits, so other widths are refused at elaboration.
  if (FAW != 12 || HAW < 1 || HAW > 8) begin : g_param_check
    $error("stx_core: FAW must be 12 and HAW within 1..8");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    stx_state_t st;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic awready;
    logic wready;
    logic arready;
    logic xinst;
    logic [3:0] bank_select_register;
    logic [15:0] instr;
    logic [15:0] next_word;
    logic [7:0] wreg;
    logic [4:0] status;
    logic [7:0] table_latch_reg;
    logic [21:0] table_pointer_reg;
    logic [7:0] index_base;
    logic [FAW-1:0] file_addr;
    logic [HAW-1:0] hold_addr;
    logic skipped;
    logic [3:0] cycles;
  } stx_reg_t;

  stx_reg_t r_ff;
  stx_reg_t nxt_r;

  logic [7:0] file_rdata;
  logic [7:0] hold_rdata;
  logic file_we;
  logic [FAW-1:0] file_waddr;
  logic [FAW-1:0] file_raddr;
  logic hold_we;
  logic [HAW-1:0] hold_waddr;
  logic [7:0] hold_wdata;
  logic [FAW-1:0] eff_addr;
  logic two_word;
  logic wr_fire;
  logic [7:0] xor_res;
  logic [15:0] addr_op;

  // Bank and indexed address selection for the tested file. The lookup is issued in the
  // cycle that takes the instruction write, so the word then still sits in the write data.
  assign addr_op = (r_ff.st == STX_IDLE) ? r_ff.wdata[15:0] : r_ff.instr;
  always_comb begin
    if (!addr_op[8]) begin
      if (r_ff.xinst && addr_op[7:0] <= INDEX_LIMIT) begin
        eff_addr = {4'h0, 8'(r_ff.index_base + addr_op[7:0])};
      end else if (addr_op[7:0] < ACCESS_SPLIT) begin
        eff_addr = {4'h0, addr_op[7:0]};
      end else begin
        eff_addr = {ACCESS_HI_BANK, addr_op[7:0]};
      end
    end else begin
      eff_addr = {r_ff.bank_select_register, addr_op[7:0]};
    end
  end

  assign two_word = (r_ff.next_word[15:12] == OP_TWO_WORD_A) ||
                    (r_ff.next_word[15:8] == OP_TWO_WORD_C) ||
                    (r_ff.next_word[15:8] == OP_TWO_WORD_D) ||
                    (r_ff.next_word[15:8] == OP_TWO_WORD_E) ||
                    (r_ff.next_word[15:8] == OP_TWO_WORD_F) ||
                    (r_ff.next_word[15:12] == OP_TWO_WORD_B &&
                     r_ff.next_word[11:9] == OP_TWO_WORD_B_SUB);
  assign xor_res = r_ff.wreg ^ r_ff.instr[7:0];
  assign wr_fire = r_ff.aw_got && r_ff.w_got && !r_ff.bvalid;
  assign file_raddr = (r_ff.st == STX_IDLE && !(wr_fire && r_ff.awaddr == REG_INSTR)) ?
                      r_ff.file_addr : eff_addr;
  assign file_we = wr_fire && r_ff.awaddr == REG_FILE_DATA && r_ff.wstrb[0];
  assign file_waddr = r_ff.file_addr;
  assign hold_we = (r_ff.st == STX_TW2) ||
                   (wr_fire && r_ff.awaddr == REG_HOLD_DATA && r_ff.wstrb[0]);
  assign hold_waddr = (r_ff.st == STX_TW2) ? r_ff.table_pointer_reg[HAW-1:0] : r_ff.hold_addr;
  assign hold_wdata = (r_ff.st == STX_TW2) ? r_ff.table_latch_reg : r_ff.wdata[7:0];

  stx_mem #(.AW(FAW)) u_file (
    .aclk(aclk),
    .we(file_we),
    .waddr(file_waddr),
    .wdata(r_ff.wdata[7:0]),
    .raddr(file_raddr),
    .rdata(file_rdata)
  );

  stx_mem #(.AW(HAW)) u_hold (
    .aclk(aclk),
    .we(hold_we),
    .waddr(hold_waddr),
    .wdata(hold_wdata),
    .raddr(r_ff.hold_addr),
    .rdata(hold_rdata)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_r = r_ff;
    if (s_axi_awvalid && !r_ff.aw_got) begin
      nxt_r.aw_got = 1'b1;
      nxt_r.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r_ff.w_got) begin
      nxt_r.w_got = 1'b1;
      nxt_r.wdata = s_axi_wdata;
      nxt_r.wstrb = s_axi_wstrb;
    end
    if (r_ff.bvalid && s_axi_bready) begin
      nxt_r.bvalid = 1'b0;
      nxt_r.aw_got = 1'b0;
      nxt_r.w_got = 1'b0;
    end
    if (r_ff.rvalid && s_axi_rready) begin
      nxt_r.rvalid = 1'b0;
    end
    unique case (r_ff.st)
      STX_IDLE: begin
      end
      STX_EXEC: begin
        nxt_r.cycles = r_ff.cycles + 4'h1;
        nxt_r.st = STX_IDLE;
        if (r_ff.instr[15:9] == OP_TEST_SKIP_HI) begin
          // File data was looked up in the previous clock; flags untouched.
          if (file_rdata == ZERO_BYTE) begin
            nxt_r.skipped = 1'b1;
            nxt_r.st = STX_SKIP1;
          end
        end else if (r_ff.instr[15:8] == OP_XOR_LIT_HI) begin
          nxt_r.wreg = xor_res;
          nxt_r.status[ST_N_BIT] = xor_res[7];
          nxt_r.status[ST_Z_BIT] = (xor_res == ZERO_BYTE);
        end else if (r_ff.instr[15:2] == OP_TABLE_WR_BASE) begin
          if (r_ff.instr[1:0] == TW_PREINC) begin
            nxt_r.table_pointer_reg = r_ff.table_pointer_reg + 22'h1;
          end
          nxt_r.st = STX_TW2;
        end
      end
      STX_SKIP1: begin
        nxt_r.cycles = r_ff.cycles + 4'h1;
        nxt_r.st = two_word ? STX_SKIP2 : STX_IDLE;
      end
      STX_SKIP2: begin
        nxt_r.cycles = r_ff.cycles + 4'h1;
        nxt_r.st = STX_IDLE;
      end
      STX_TW2: begin
        nxt_r.cycles = r_ff.cycles + 4'h1;
        nxt_r.st = STX_IDLE;
        unique case (r_ff.instr[1:0])
          TW_POSTINC: nxt_r.table_pointer_reg = r_ff.table_pointer_reg + 22'h1;
          TW_POSTDEC: nxt_r.table_pointer_reg = r_ff.table_pointer_reg - 22'h1;
          TW_PLAIN, TW_PREINC: begin
          end
        endcase
      end
    endcase
    if (wr_fire) begin
      nxt_r.bvalid = 1'b1;
      nxt_r.bresp = RESP_OKAY;
      unique case (r_ff.awaddr)
        REG_CTRL: begin
          nxt_r.xinst = r_ff.wdata[CTRL_XINST_BIT];
          nxt_r.bank_select_register = r_ff.wdata[CTRL_BANK_LSB+:4];
          nxt_r.index_base = r_ff.wdata[CTRL_BASE_LSB+:8];
        end
        REG_INSTR: begin
          // Writing an instruction while one runs is refused.
          if (r_ff.st == STX_IDLE) begin
            nxt_r.instr = r_ff.wdata[15:0];
            nxt_r.next_word = r_ff.wdata[31:16];
            nxt_r.cycles = 4'h0;
            nxt_r.skipped = 1'b0;
            nxt_r.st = STX_EXEC;
          end else begin
            nxt_r.bresp = RESP_SLVERR;
          end
        end
        REG_WREG: nxt_r.wreg = r_ff.wdata[7:0];
        REG_STATUS: nxt_r.status = r_ff.wdata[4:0];
        REG_FILE_ADDR: nxt_r.file_addr = r_ff.wdata[FAW-1:0];
        REG_FILE_DATA: begin
        end
        REG_TPTR: nxt_r.table_pointer_reg = r_ff.wdata[21:0];
        REG_TLAT: nxt_r.table_latch_reg = r_ff.wdata[7:0];
        REG_HOLD_ADDR: nxt_r.hold_addr = r_ff.wdata[HAW-1:0];
        REG_HOLD_DATA: begin
        end
        default: nxt_r.bresp = RESP_SLVERR;
      endcase
    end
    if (s_axi_arvalid && !r_ff.rvalid) begin
      nxt_r.rvalid = 1'b1;
      nxt_r.rresp = RESP_OKAY;
      nxt_r.rdata = 32'h0;
      unique case (s_axi_araddr)
        REG_CTRL: nxt_r.rdata = {8'h0, r_ff.index_base, 4'h0, r_ff.bank_select_register,
                                 7'h0, r_ff.xinst};
        REG_INSTR: nxt_r.rdata = {r_ff.next_word, r_ff.instr};
        REG_WREG: nxt_r.rdata = {24'h0, r_ff.wreg};
        REG_STATUS: nxt_r.rdata = {16'h0, r_ff.cycles, 2'h0, r_ff.skipped,
                                   r_ff.st != STX_IDLE, 3'h0, r_ff.status};
        REG_FILE_ADDR: nxt_r.rdata = {{(32-FAW){1'b0}}, r_ff.file_addr};
        REG_FILE_DATA: nxt_r.rdata = {24'h0, file_rdata};
        REG_TPTR: nxt_r.rdata = {10'h0, r_ff.table_pointer_reg};
        REG_TLAT: nxt_r.rdata = {24'h0, r_ff.table_latch_reg};
        REG_HOLD_ADDR: nxt_r.rdata = {{(32-HAW){1'b0}}, r_ff.hold_addr};
        REG_HOLD_DATA: nxt_r.rdata = {24'h0, hold_rdata};
        default: nxt_r.rresp = RESP_SLVERR;
      endcase
    end
    // Ready levels are kept as flops of their own so that the ports need no gate.
    nxt_r.awready = !nxt_r.aw_got;
    nxt_r.wready = !nxt_r.w_got;
    nxt_r.arready = !nxt_r.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_ff <= '0;
      r_ff.st <= STX_IDLE;
      r_ff.status <= STATUS_RST;
      r_ff.awready <= 1'b1;
      r_ff.wready <= 1'b1;
      r_ff.arready <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign s_axi_awready = r_ff.awready;
  assign s_axi_wready = r_ff.wready;
  assign s_axi_bvalid = r_ff.bvalid;
  assign s_axi_bresp = r_ff.bresp;
  assign s_axi_arready = r_ff.arready;
  assign s_axi_rvalid = r_ff.rvalid;
  assign s_axi_rdata = r_ff.rdata;
  assign s_axi_rresp = r_ff.rresp;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_skip_on_zero: assert property (
    r_ff.st == STX_EXEC && r_ff.instr[15:9] == OP_TEST_SKIP_HI && file_rdata == ZERO_BYTE
    |=> r_ff.st == STX_SKIP1)
    else $error("zero test did not skip");
  chk_no_skip_nz: assert property (
    r_ff.st == STX_EXEC && r_ff.instr[15:9] == OP_TEST_SKIP_HI && file_rdata != ZERO_BYTE
    |=> r_ff.st == STX_IDLE)
    else $error("nonzero test skipped");
  chk_two_word_skip: assert property (
    r_ff.st == STX_SKIP1 && two_word |=> r_ff.st == STX_SKIP2 ##1 r_ff.st == STX_IDLE)
    else $error("two-word skip length wrong");
  chk_test_flags: assert property (
    r_ff.st == STX_EXEC && r_ff.instr[15:9] == OP_TEST_SKIP_HI && !wr_fire
    |=> $stable(r_ff.status))
    else $error("test changed flags");
  chk_bank_sel: assert property (
    addr_op[8] |-> eff_addr[11:8] == r_ff.bank_select_register)
    else $error("bank select not used");
  chk_indexed: assert property (
    !addr_op[8] && r_ff.xinst && addr_op[7:0] <= INDEX_LIMIT
    |-> eff_addr[7:0] == 8'(r_ff.index_base + addr_op[7:0]) && eff_addr[11:8] == 4'h0)
    else $error("indexed address wrong");
  chk_xor_result: assert property (
    r_ff.st == STX_EXEC && r_ff.instr[15:8] == OP_XOR_LIT_HI && !wr_fire
    |=> r_ff.wreg == ($past(r_ff.wreg) ^ $past(r_ff.instr[7:0])))
    else $error("xor result wrong");
  chk_xor_flags: assert property (
    r_ff.st == STX_EXEC && r_ff.instr[15:8] == OP_XOR_LIT_HI && !wr_fire
    |=> r_ff.status[ST_Z_BIT] == (r_ff.wreg == ZERO_BYTE) && r_ff.status[ST_N_BIT] == r_ff.wreg[7]
        && r_ff.status[3] == $past(r_ff.status[3]) && r_ff.status[1:0] == $past(r_ff.status[1:0]))
    else $error("xor flags wrong");
  chk_table_store: assert property (
    r_ff.st == STX_TW2 |-> hold_we && hold_wdata == r_ff.table_latch_reg)
    else $error("table write not stored");
  cov_skip1: cover property (r_ff.st == STX_SKIP1 ##1 r_ff.st == STX_IDLE);
  cov_skip2: cover property (r_ff.st == STX_SKIP2);
  cov_xor: cover property (r_ff.st == STX_EXEC && r_ff.instr[15:8] == OP_XOR_LIT_HI);
  cov_tw: cover property (r_ff.st == STX_TW2);
endmodule

// ==== verif/stx_core_tb_top.sv ====
`timescale 1ns/1ps
module stx_core_tb_top;
  import stx_pkg::*;
  // ----------------------------------------------------------------
  // Clock, reset and bus signals
  // ----------------------------------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = '0;
  logic [7:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int errors = 0;
  int comparisons = 0;

  initial begin
    forever #5 aclk = ~aclk;
  end

  // Both response channels are always ready; a master may hold them high early.
  stx_core i_stx_core (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1));

  // ----------------------------------------------------------------
  // Report and bus tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    if (errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic hang();
    errors++;
    $display("CHECK FAILED at %0t: bus wait ran out", $time);
    conclude();
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit ad, wd;
    int n;
    ad = 0;
    wd = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (ad && wd && bvalid) begin
        r = bresp;
        return;
      end
      if (!ad && awready) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    hang();
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ad;
    int n;
    ad = 0;
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (ad && rvalid) begin
        d = rdata;
        r = rresp;
        return;
      end
      if (!ad && arready) begin
        ad = 1;
        arvalid <= 1'b0;
      end
    end
    hang();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY}, "write response");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY}, "read response");
    chk(d, exp, msg);
  endtask

  // Issues one instruction and returns the status word once busy has dropped.
  task automatic exec(input logic [31:0] w, output logic [31:0] st);
    logic [1:0] r;
    int n;
    wr(REG_INSTR, w);
    for (n = 0; n < 20; n++) begin
      axi_rd(REG_STATUS, st, r);
      if (st[ST_BUSY_BIT] === 1'b0) begin
        return;
      end
    end
    hang();
  endtask

  task automatic put_file(input logic [11:0] fa, input logic [7:0] v);
    wr(REG_FILE_ADDR, {20'h0, fa});
    wr(REG_FILE_DATA, {24'h0, v});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic xor_run(input logic [7:0] k, input logic [7:0] w, input logic [4:0] fl);
    logic [31:0] st;
    exec({16'h0, OP_XOR_LIT_HI, k}, st);
    rd(REG_WREG, {24'h0, w}, "xor result");
    chk({27'h0, st[4:0]}, {27'h0, fl}, "xor flags");
    chk({28'h0, st[ST_CYC_LSB+:4]}, 32'h1, "xor cycles");
  endtask

  // Flags are expected to keep the value left by the last logic operation.
  task automatic tst(input logic [31:0] w, input logic [3:0] cyc, input logic sk);
    logic [31:0] st;
    exec(w, st);
    chk({28'h0, st[ST_CYC_LSB+:4]}, {28'h0, cyc}, "test cycles");
    chk({31'h0, st[ST_SKIP_BIT]}, {31'h0, sk}, "test skip");
    chk({27'h0, st[4:0]}, 32'h10, "test flags");
  endtask

  task automatic tw(input logic [1:0] md, input logic [21:0] p, input logic [7:0] lat,
                    input logic [21:0] pe, input logic [5:0] ix);
    logic [31:0] st;
    wr(REG_TLAT, {24'h0, lat});
    wr(REG_TPTR, {10'h0, p});
    exec({16'h0, OP_TABLE_WR_BASE, md}, st);
    chk({28'h0, st[ST_CYC_LSB+:4]}, 32'h2, "table write cycles");
    rd(REG_TPTR, {10'h0, pe}, "table pointer");
    wr(REG_HOLD_ADDR, {26'h0, ix});
    rd(REG_HOLD_DATA, {24'h0, lat}, "holding byte");
  endtask

  // A second instruction written during a two-word skip must be refused and dropped.
  task automatic busy_refuse();
    logic [1:0] r;
    wr(REG_INSTR, 32'hc000_6610);
    axi_wr(REG_INSTR, {16'h0, OP_XOR_LIT_HI, 8'hff}, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "write while busy");
  endtask

  task automatic unmapped();
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(8'h40, 32'h1, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
    axi_rd(8'h44, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped read");
    chk(d, 32'h0, "unmapped data");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(REG_STATUS, 32'h0, "status after reset");
    wr(REG_WREG, 32'hb5);
    xor_run(8'haf, 8'h1a, 5'h00);
    xor_run(8'h1a, 8'h00, 5'h04);
    xor_run(8'h80, 8'h80, 5'h10);
    put_file(12'h010, 8'h00);
    tst(32'h0000_6610, 4'h2, 1'b1);
    tst(32'hc000_6610, 4'h3, 1'b1);
    tst(32'hee00_6610, 4'h3, 1'b1);
    busy_refuse();
    xor_run(8'h00, 8'h80, 5'h10);
    put_file(12'h010, 8'h5a);
    tst(32'h0000_6610, 4'h1, 1'b0);
    wr(REG_CTRL, 32'h0000_0300);
    put_file(12'h320, 8'h00);
    put_file(12'h020, 8'h11);
    tst(32'h0000_6720, 4'h2, 1'b1);
    tst(32'h0000_6620, 4'h1, 1'b0);
    put_file(12'hf70, 8'h00);
    tst(32'h0000_6670, 4'h2, 1'b1);
    wr(REG_CTRL, 32'h0040_0001);
    put_file(12'h045, 8'h00);
    put_file(12'h005, 8'h22);
    tst(32'h0000_6605, 4'h2, 1'b1);
    put_file(12'h09f, 8'h00);
    put_file(12'h05f, 8'h44);
    tst(32'h0000_665f, 4'h2, 1'b1);
    put_file(12'hf60, 8'h33);
    put_file(12'h0a0, 8'h00);
    tst(32'h0000_6660, 4'h1, 1'b0);
    tw(TW_POSTINC, 22'h00a356, 8'h55, 22'h00a357, 6'h16);
    tw(TW_PREINC, 22'h01389a, 8'h34, 22'h01389b, 6'h1b);
    tw(TW_POSTDEC, 22'h000010, 8'h77, 22'h00000f, 6'h10);
    tw(TW_PLAIN, 22'h000020, 8'h99, 22'h000020, 6'h20);
    unmapped();
    conclude();
  end
endmodule
